// ===== inc/eel_pkg.sv
// Package for the edge event line controller: register map, widths, layout
package eel_pkg;
    localparam int unsigned EEL_NUM_LINES   = 19;
    localparam int unsigned EEL_NUM_EXT     = 16;
    localparam int unsigned EEL_NUM_PORTS   = 5;
    localparam int unsigned EEL_PORT_SEL_W  = 3;
    localparam int unsigned EEL_PIN_COUNT   = EEL_NUM_EXT * EEL_NUM_PORTS;
    localparam int unsigned EEL_LINE_SUPPLY = 16;
    localparam int unsigned EEL_LINE_ALARM  = 17;
    localparam int unsigned EEL_LINE_AUX    = 18;
    localparam int unsigned EEL_ADDR_W      = 8;
    localparam int unsigned EEL_DATA_W      = 32;
    // Register byte offsets
    localparam logic [7:0] EEL_OFS_INT_MASK  = 8'h00;
    localparam logic [7:0] EEL_OFS_EVT_MASK  = 8'h04;
    localparam logic [7:0] EEL_OFS_RISE_SEL  = 8'h08;
    localparam logic [7:0] EEL_OFS_FALL_SEL  = 8'h0C;
    localparam logic [7:0] EEL_OFS_SW_TRIG   = 8'h10;
    localparam logic [7:0] EEL_OFS_PENDING   = 8'h14;
    localparam logic [7:0] EEL_OFS_PORT_SEL0 = 8'h18;
    localparam logic [7:0] EEL_OFS_PORT_SEL1 = 8'h1C;
    localparam logic [7:0] EEL_OFS_LEVEL     = 8'h20;
    localparam int unsigned EEL_SEL_PER_REG  = 8;
    localparam int unsigned EEL_SEL_FIELD_W  = 4;
    localparam logic [31:0] EEL_RST_ZERO     = 32'h0000_0000;
endpackage : eel_pkg

// ===== hdl/eel_top.sv
// Edge event line controller: edge capture, mask, pending store, pin routing
// How it works
// - Nineteen edge lines raise interrupt or event
// - Per line rising, falling or both edges
// - Independent mask per line
// - Pending bit per line, software readable
// - Edge on lines 0-15 caught even if shorter than clock
// - Eighty pins select onto sixteen lines
// - Supply, alarm lines; any unmasked line wakes stop
//
// The register addresses and the address-and-strobe port were left to the implementer.
module eel_top
    import eel_pkg::*;
#(
    parameter int unsigned NUM_LINES = EEL_NUM_LINES,
    parameter int unsigned NUM_PORTS = EEL_NUM_PORTS
) (
    // Clock and reset
    input  wire logic                           clk_sys_i,
    input  wire logic                           reset_i,
    // Register port
    input  wire logic [EEL_ADDR_W-1:0]          reg_addr_i,
    input  wire logic [EEL_DATA_W-1:0]          reg_wdata_i,
    input  wire logic                           reg_wr_i,
    input  wire logic                           reg_rd_i,
    output logic      [EEL_DATA_W-1:0]          reg_rdata_o,
    // Sources
    input  wire logic [NUM_PORTS*EEL_NUM_EXT-1:0] gpio_pins_i,
    input  wire logic [EEL_NUM_EXT-1:0]         ext_edge_rise_i,
    input  wire logic [EEL_NUM_EXT-1:0]         ext_edge_fall_i,
    input  wire logic                           supply_monitor_output_i,
    input  wire logic                           alarm_i,
    input  wire logic                           aux_src_i,
    // Toward processor_interrupt_controller
    output logic      [NUM_LINES-1:0]           irq_req_o,
    output logic      [NUM_LINES-1:0]           evt_pulse_o,
    output logic                                wake_o
);
    // Register state
    logic [NUM_LINES-1:0] int_mask_ff, nxt_int_mask;
    logic [NUM_LINES-1:0] evt_mask_ff, nxt_evt_mask;
    logic [NUM_LINES-1:0] rise_sel_ff, nxt_rise_sel;
    logic [NUM_LINES-1:0] fall_sel_ff, nxt_fall_sel;
    logic [NUM_LINES-1:0] swtrig_ff, nxt_swtrig;
    logic [NUM_LINES-1:0] pend_ff, nxt_pend;
    logic [EEL_DATA_W-1:0] psel0_ff, nxt_psel0;
    logic [EEL_DATA_W-1:0] psel1_ff, nxt_psel1;
    logic [EEL_DATA_W-1:0] rdata_ff, nxt_rdata;
    // Line sampling and edges
    logic [NUM_LINES-1:0] line_lvl;
    logic [NUM_LINES-1:0] line_prev_ff, nxt_line_prev;
    logic [NUM_LINES-1:0] irq_ff, nxt_irq;
    logic [NUM_LINES-1:0] evt_ff, nxt_evt;
    logic                 wake_ff, nxt_wake;
    logic [NUM_LINES-1:0] rise_hit;
    logic [NUM_LINES-1:0] fall_hit;
    logic [NUM_LINES-1:0] trig;
    logic [NUM_LINES-1:0] wr_mask;

    // Pin selection per external line
    genvar gi;
    generate
        for (gi = 0; gi < EEL_NUM_EXT; gi++) begin : g_ext
            logic [EEL_PORT_SEL_W-1:0] sel;
            logic [EEL_DATA_W-1:0]     sel_reg;
            logic [NUM_PORTS-1:0]      port_pins;
            always_comb begin
                sel_reg = (gi < EEL_SEL_PER_REG) ? psel0_ff : psel1_ff;
                sel = sel_reg[(gi % EEL_SEL_PER_REG)*EEL_SEL_FIELD_W +: EEL_PORT_SEL_W];
                for (int p = 0; p < NUM_PORTS; p++) begin
                    port_pins[p] = gpio_pins_i[p*EEL_NUM_EXT + gi];
                end
            end
            // Out-of-range selection reads the pin as low
            assign line_lvl[gi] = (int'(sel) < NUM_PORTS) ? port_pins[sel] : 1'b0;
            // Pulse shorter than a clock: async edge catchers outside feed these
            assign rise_hit[gi] = ext_edge_rise_i[gi] ||
                                  (line_lvl[gi] && !line_prev_ff[gi]);
            assign fall_hit[gi] = ext_edge_fall_i[gi] ||
                                  (!line_lvl[gi] && line_prev_ff[gi]);
        end
        for (gi = EEL_NUM_EXT; gi < NUM_LINES; gi++) begin : g_int
            assign line_lvl[gi] = (gi == EEL_LINE_SUPPLY) ? supply_monitor_output_i :
                                  (gi == EEL_LINE_ALARM)  ? alarm_i : aux_src_i;
            assign rise_hit[gi] = line_lvl[gi] && !line_prev_ff[gi];
            assign fall_hit[gi] = !line_lvl[gi] && line_prev_ff[gi];
        end
    endgenerate

    // Edge selection per line, software trigger ORed in
    assign trig = (rise_hit & rise_sel_ff) | (fall_hit & fall_sel_ff) | swtrig_ff;
    assign wr_mask = reg_wdata_i[NUM_LINES-1:0];

    always_comb begin
        nxt_int_mask  = int_mask_ff;
        nxt_evt_mask  = evt_mask_ff;
        nxt_rise_sel  = rise_sel_ff;
        nxt_fall_sel  = fall_sel_ff;
        nxt_psel0     = psel0_ff;
        nxt_psel1     = psel1_ff;
        nxt_swtrig    = '0;
        nxt_pend      = pend_ff;
        nxt_line_prev = line_lvl;
        nxt_rdata     = EEL_RST_ZERO;
        if (reg_wr_i) begin
            if (reg_addr_i == EEL_OFS_INT_MASK) begin
                nxt_int_mask = wr_mask;
            end else if (reg_addr_i == EEL_OFS_EVT_MASK) begin
                nxt_evt_mask = wr_mask;
            end else if (reg_addr_i == EEL_OFS_RISE_SEL) begin
                nxt_rise_sel = wr_mask;
            end else if (reg_addr_i == EEL_OFS_FALL_SEL) begin
                nxt_fall_sel = wr_mask;
            end else if (reg_addr_i == EEL_OFS_SW_TRIG) begin
                nxt_swtrig = wr_mask;
            end else if (reg_addr_i == EEL_OFS_PENDING) begin
                nxt_pend = pend_ff & ~wr_mask;
            end else if (reg_addr_i == EEL_OFS_PORT_SEL0) begin
                nxt_psel0 = reg_wdata_i;
            end else if (reg_addr_i == EEL_OFS_PORT_SEL1) begin
                nxt_psel1 = reg_wdata_i;
            end
        end
        // Set wins over a clear in the same cycle
        nxt_pend = nxt_pend | (trig & int_mask_ff);
        if (reg_rd_i) begin
            if (reg_addr_i == EEL_OFS_INT_MASK) begin
                nxt_rdata[NUM_LINES-1:0] = int_mask_ff;
            end else if (reg_addr_i == EEL_OFS_EVT_MASK) begin
                nxt_rdata[NUM_LINES-1:0] = evt_mask_ff;
            end else if (reg_addr_i == EEL_OFS_RISE_SEL) begin
                nxt_rdata[NUM_LINES-1:0] = rise_sel_ff;
            end else if (reg_addr_i == EEL_OFS_FALL_SEL) begin
                nxt_rdata[NUM_LINES-1:0] = fall_sel_ff;
            end else if (reg_addr_i == EEL_OFS_PENDING) begin
                nxt_rdata[NUM_LINES-1:0] = pend_ff;
            end else if (reg_addr_i == EEL_OFS_PORT_SEL0) begin
                nxt_rdata = psel0_ff;
            end else if (reg_addr_i == EEL_OFS_PORT_SEL1) begin
                nxt_rdata = psel1_ff;
            end else if (reg_addr_i == EEL_OFS_LEVEL) begin
                nxt_rdata[NUM_LINES-1:0] = line_lvl;
            end
        end
        nxt_irq  = nxt_pend;
        nxt_evt  = trig & evt_mask_ff;
        // Any unmasked request or event wakes stop mode
        nxt_wake = |((trig & int_mask_ff) | (trig & evt_mask_ff) | pend_ff);
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            int_mask_ff  <= '0;
            evt_mask_ff  <= '0;
            rise_sel_ff  <= '0;
            fall_sel_ff  <= '0;
            swtrig_ff    <= '0;
            pend_ff      <= '0;
            psel0_ff     <= EEL_RST_ZERO;
            psel1_ff     <= EEL_RST_ZERO;
            rdata_ff     <= EEL_RST_ZERO;
            line_prev_ff <= '0;
            irq_ff       <= '0;
            evt_ff       <= '0;
            wake_ff      <= 1'b0;
        end else begin
            int_mask_ff  <= nxt_int_mask;
            evt_mask_ff  <= nxt_evt_mask;
            rise_sel_ff  <= nxt_rise_sel;
            fall_sel_ff  <= nxt_fall_sel;
            swtrig_ff    <= nxt_swtrig;
            pend_ff      <= nxt_pend;
            psel0_ff     <= nxt_psel0;
            psel1_ff     <= nxt_psel1;
            rdata_ff     <= nxt_rdata;
            line_prev_ff <= nxt_line_prev;
            irq_ff       <= nxt_irq;
            evt_ff       <= nxt_evt;
            wake_ff      <= nxt_wake;
        end
    end

    assign reg_rdata_o = rdata_ff;
    assign irq_req_o   = irq_ff;
    assign evt_pulse_o = evt_ff;
    assign wake_o      = wake_ff;
endmodule : eel_top

// ===== testbench/eel_pin_model.sv
// Pin side model: port pins and async short pulse catchers
module eel_pin_model
    import eel_pkg::*;
(
    // From the bench
    input  wire logic                     clk_sys_i,
    input  wire logic [EEL_PIN_COUNT-1:0] pins_req_i,
    input  wire logic [EEL_NUM_EXT-1:0]   rise_req_i,
    input  wire logic [EEL_NUM_EXT-1:0]   fall_req_i,
    // Toward the controller
    output logic      [EEL_PIN_COUNT-1:0] gpio_pins_o,
    output logic      [EEL_NUM_EXT-1:0]   ext_edge_rise_o,
    output logic      [EEL_NUM_EXT-1:0]   ext_edge_fall_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Catchers register each request, so it appears as a strobe one clock later
    always_ff @(posedge clk_sys_i) begin
        gpio_pins_o     <= pins_req_i;
        ext_edge_rise_o <= rise_req_i;
        ext_edge_fall_o <= fall_req_i;
    end
endmodule : eel_pin_model

// ===== testbench/eel_checker_asserts.sv
// Port assertions for the edge event line controller
module eel_checker
    import eel_pkg::*;
#(
    parameter int unsigned NUM_LINES = EEL_NUM_LINES,
    parameter int unsigned NUM_PORTS = EEL_NUM_PORTS
) (
    input wire logic                  clk_sys_i,
    input wire logic                  reset_i,
    input wire logic [EEL_ADDR_W-1:0] reg_addr_i,
    input wire logic [EEL_DATA_W-1:0] reg_wdata_i,
    input wire logic                  reg_wr_i,
    input wire logic                  reg_rd_i,
    input wire logic [EEL_DATA_W-1:0] reg_rdata_o,
    input wire logic [NUM_LINES-1:0]  irq_req_o,
    input wire logic [NUM_LINES-1:0]  evt_pulse_o,
    input wire logic                  wake_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    chk_idle_read_zero: assert property (!$past(reg_rd_i) |-> reg_rdata_o == '0)
        else $error("read data not idle");
    chk_pend_read: assert property ($past(reg_rd_i && reg_addr_i == EEL_OFS_PENDING) |->
        reg_rdata_o == 32'($past(irq_req_o))) else $error("pending read mismatch");
    chk_hidden_read: assert property ($past(reg_rd_i && (reg_addr_i == EEL_OFS_SW_TRIG ||
        reg_addr_i > EEL_OFS_LEVEL)) |-> reg_rdata_o == '0) else $error("hidden read not zero");
    chk_mask_upper: assert property ($past(reg_rd_i && reg_addr_i == EEL_OFS_INT_MASK) |->
        reg_rdata_o[31:19] == '0) else $error("mask upper bits set");
    chk_clear_write: assert property (|($past(irq_req_o) & ~irq_req_o) |->
        $past(reg_wr_i) && $past(reg_addr_i) == EEL_OFS_PENDING) else $error("lost pend");
    chk_clear_ones: assert property (($past(irq_req_o) & ~irq_req_o
        & ~$past(reg_wdata_i[NUM_LINES-1:0])) == '0) else $error("pend cleared by zero");
    chk_wake_pend: assert property (|irq_req_o |-> wake_o) else $error("no wake");
    chk_wake_event: assert property (|evt_pulse_o |-> ##[0:1] wake_o)
        else $error("no wake on event");
endmodule : eel_checker
bind eel_top eel_checker #(.NUM_LINES(NUM_LINES), .NUM_PORTS(NUM_PORTS)) eel_checker_i (
    .clk_sys_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .irq_req_o, .evt_pulse_o, .wake_o);

// ===== testbench/edge_event_line_controller_tb_top.sv
// Self-checking bench for the edge event line controller
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin err_count++; \
    $display("wrong value %s expected %h seen %h", n, e, s); end end
module edge_event_line_controller_tb_top;
    import eel_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, wr_s = 0, rd_s = 0, sup = 0, alm = 0, aux = 0, wake;
    logic [7:0] addr = '0;
    logic [31:0] wd = '0, rdata, q;
    logic [79:0] pins = '0, gpio;
    logic [15:0] rq = '0, fq = '0, er, ef;
    logic [18:0] irq, evt, pend = '0, lvl = '0, imsk, emsk, rs, fs, evacc = '0;
    int err_count = 0, checks_done = 0, sel[16];
    always #2 clk = ~clk;
    always @(posedge clk) evacc = evacc | evt;
    eel_pin_model eel_pin_model_i (.clk_sys_i(clk), .pins_req_i(pins), .rise_req_i(rq),
        .fall_req_i(fq), .gpio_pins_o(gpio), .ext_edge_rise_o(er), .ext_edge_fall_o(ef));
    eel_top eel_top_i (.clk_sys_i(clk), .reset_i(rst), .reg_addr_i(addr), .reg_wdata_i(wd),
        .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata), .gpio_pins_i(gpio),
        .ext_edge_rise_i(er), .ext_edge_fall_i(ef), .supply_monitor_output_i(sup),
        .alarm_i(alm), .aux_src_i(aux), .irq_req_o(irq), .evt_pulse_o(evt), .wake_o(wake));
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wd <= d;
        wr_s <= '1;
        @(posedge clk);
        wr_s <= '0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        addr <= a;
        rd_s <= '1;
        @(posedge clk);
        rd_s <= '0;
        @(negedge clk);
        q = rdata;
        @(posedge clk);
    endtask : rd
    function automatic logic [18:0] lines_of(input logic [79:0] p, input logic [2:0] x);
        logic [18:0] v;
        for (int l = 0; l < 16; l++) v[l] = (sel[l] < 5) ? p[sel[l] * 16 + l] : '0;
        v[18:16] = x;
        return v;
    endfunction : lines_of
    task automatic complete_run();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : complete_run
    task automatic cfg_phase();
        logic [31:0] s0, s1;
        wr(EEL_OFS_RISE_SEL, '0);
        wr(EEL_OFS_FALL_SEL, '0);
        for (int l = 0; l < 16; l++) sel[l] = $urandom % 8;
        for (int l = 0; l < 8; l++) {s1[l*4 +: 4], s0[l*4 +: 4]} = {4'(sel[l+8]), 4'(sel[l])};
        wr(EEL_OFS_PORT_SEL0, s0);
        wr(EEL_OFS_PORT_SEL1, s1);
        lvl = lines_of(pins, {aux, alm, sup});
        {imsk, emsk, rs, fs} = {19'($urandom), 19'($urandom), 19'($urandom), 19'($urandom)};
        wr(EEL_OFS_INT_MASK, 32'(imsk));
        wr(EEL_OFS_EVT_MASK, 32'(emsk));
        wr(EEL_OFS_RISE_SEL, 32'(rs));
        wr(EEL_OFS_FALL_SEL, 32'(fs));
        rd(EEL_OFS_INT_MASK);
        `CHK("int mask", 32'(imsk), q)
        rd(EEL_OFS_PORT_SEL1);
        `CHK("select", s1, q)
    endtask : cfg_phase
    task automatic step();
        logic [79:0] np;
        logic [15:0] nr, nf;
        logic [18:0] nl, ed, sw;
        {np, nr, nf, sw} = {80'({$urandom, $urandom, $urandom}), 32'($urandom), 19'($urandom)};
        nl = lines_of(np, 3'($urandom));
        evacc = '0;
        pins <= np;
        {aux, alm, sup} <= nl[18:16];
        {rq, fq} <= {nr, nf};
        @(posedge clk);
        {rq, fq} <= '0;
        wr(EEL_OFS_SW_TRIG, 32'(sw));
        ed = (~lvl & nl & rs) | (lvl & ~nl & fs) | 19'(nr & rs[15:0]) | 19'(nf & fs[15:0]) | sw;
        pend = pend | (ed & imsk);
        repeat (4) @(posedge clk);
        `CHK("event", ed & emsk, evacc)
        rd(EEL_OFS_PENDING);
        `CHK("pending", 32'(pend), q)
        `CHK("irq", pend, irq)
        `CHK("wake", |pend, wake)
        rd(EEL_OFS_LEVEL);
        `CHK("level", 32'(nl), q)
        sw = 19'($urandom);
        wr(EEL_OFS_PENDING, 32'(sw));
        pend = pend & ~sw;
        lvl = nl;
    endtask : step
    initial begin
        void'($urandom(32'h8657_3f50));
        repeat (3) @(posedge clk);
        rst <= '0;
        for (int a = 0; a <= 64; a += 4) begin
            rd(8'(a));
            `CHK("reset value", 32'h0000_0000, q)
        end
        for (int ph = 0; ph < 8; ph++) begin
            cfg_phase();
            repeat (10) step();
        end
        complete_run();
    end
    // Whole run needs about 1240 cycles
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        complete_run();
    end
endmodule : edge_event_line_controller_tb_top
